// file: e1rs_map.svh
`ifndef E1RS_MAP_SVH
`define E1RS_MAP_SVH
// register offsets
`define E1RS_ADDR_ID 8'h0F
`define E1RS_ADDR_RC1 8'h10
`define E1RS_ADDR_RC2 8'h11
// reset values
`define E1RS_RC1_RST 8'h00
`define E1RS_RC2_RST 8'h00
`define E1RS_UNMAPPED_RD 8'h00
// receive_control_one fields
`define E1RS_RC1_MFFUNC 7
`define E1RS_RC1_MODE 6
`define E1RS_RC1_DIR 5
`define E1RS_RC1_CRIT 2
`define E1RS_RC1_AUTODIS 1
`define E1RS_RC1_MANUAL 0
// receive_control_two fields
`define E1RS_RC2_BCS 2
`define E1RS_RC2_ESE 1
// frame structure
`define E1RS_FAS_WORD 7'h1B
`define E1RS_CRC_MFA_WORD 6'h0B
`define E1RS_TS0_END 8'h07
`define E1RS_TS16_END 8'h87
`define E1RS_FRAME_END 8'hFF
// timing and error counts
`define E1RS_FAS_ERR_LIMIT 2'h3
`define E1RS_CAS_ERR_LIMIT 2'h2
`define E1RS_MF_WINDOW_US 8000
`define E1RS_FRAME_US 125
`define E1RS_CRC_BLOCK 1000
`define E1RS_CRC_ERR_LIMIT 915
`endif

// file: e1rs_pkg.sv
package e1rs_pkg;
  typedef enum logic [1:0] {
    E1RS_HUNT = 2'b00,
    E1RS_NFAS = 2'b01,
    E1RS_CONF = 2'b11,
    E1RS_SYNC = 2'b10
  } e1rs_fstate_e;
  typedef logic [7:0] e1rs_byte_t;
endpackage

// file: e1rs_receive_sync.sv
`timescale 1ns/1ps
`include "e1rs_map.svh"
// Notes on behaviour
// - identification register at 0Fh, read only, top bit set by LINE_TYPE
// - low four bits give die revision, bits 6 to 4 read zero
// - bit 7 reads 0 for T1 part, 1 for E1 part
// - control registers reset to 00h and hold that until the host writes them
// - multiframe mode marks CAS boundaries at 0, CRC4 boundaries at 1
// - sync pin marks every second (FAS) frame at 0, multiframes at 1
// - direction 0 output, 1 input; input only with elastic store on
// - resync after 3 bad FAS; optionally also 3 bad non-FAS bit 2
// - auto realign disable bit: 0 realigns automatically, 1 does not
// - rising edge of manual resync bit starts a resync
// - frame sync: FAS in frame N and N+2, absent in N+1
// - CRC4 multiframe sync: two alignment words within 8 ms
// - CRC4 resync when 915 or more of 1000 code words errored
// - CAS sync on word with nonzero previous TS16; resync after two bad
// - elastic store enable bit bypasses at 0, inserts at 1
// - spare bit selects in second control register have no function
module e1rs_receive_sync
  import e1rs_pkg::*;
#(
  parameter logic [3:0] REVISION = 4'h1, // arbitrary value
  parameter logic LINE_TYPE = 1'b1
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  output logic [7:0] bus_rdata_o,
  input wire logic rx_bit_i,
  input wire logic rx_bit_en_i,
  input wire logic rx_boundary_pin_i,
  output logic rx_boundary_pin_o,
  output logic rx_boundary_pin_oe_o,
  output logic backplane_sync_o,
  output logic rx_elastic_store_enable_o,
  output logic backplane_clock_select_o,
  output logic frame_sync_o,
  output logic crc_mf_sync_o,
  output logic cas_mf_sync_o
);
  localparam int WIN_FRAMES = `E1RS_MF_WINDOW_US / `E1RS_FRAME_US;
  localparam logic [6:0] WIN_LAST = 7'(WIN_FRAMES - 1);
  localparam logic [9:0] CRC_LAST = 10'(`E1RS_CRC_BLOCK - 1);
  localparam logic [9:0] CRC_LIM = 10'(`E1RS_CRC_ERR_LIMIT);

  //////////////////////////////////////////////////////////////////////////
  // register port
  e1rs_byte_t receive_control_one;
  e1rs_byte_t receive_control_two;
  wire e1rs_byte_t die_identification =
    {LINE_TYPE, 3'h0, REVISION};
  wire sel_id = bus_addr_i == `E1RS_ADDR_ID;
  wire sel_rc1 = bus_addr_i == `E1RS_ADDR_RC1;
  wire sel_rc2 = bus_addr_i == `E1RS_ADDR_RC2;
  wire e1rs_byte_t rd_mux = sel_id ? die_identification :
    sel_rc1 ? receive_control_one :
    sel_rc2 ? receive_control_two : `E1RS_UNMAPPED_RD;
  wire sync_pin_multiframe_function =
    receive_control_one[`E1RS_RC1_MFFUNC];
  wire sync_pin_mode = receive_control_one[`E1RS_RC1_MODE];
  wire sync_pin_direction = receive_control_one[`E1RS_RC1_DIR];
  wire realign_criteria_select = receive_control_one[`E1RS_RC1_CRIT];
  wire auto_realign_disable = receive_control_one[`E1RS_RC1_AUTODIS];
  wire manual_bit = receive_control_one[`E1RS_RC1_MANUAL];
  wire es_enable = receive_control_two[`E1RS_RC2_ESE];
  // spare selects in bits 7..3 are stored only
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      receive_control_one <= `E1RS_RC1_RST;
      receive_control_two <= `E1RS_RC2_RST;
      bus_rdata_o <= `E1RS_UNMAPPED_RD;
    end else if (ce_i) begin
      if (bus_wr_i && sel_rc1) begin
        receive_control_one <= bus_wdata_i;
      end
      if (bus_wr_i && sel_rc2) begin
        receive_control_two <= bus_wdata_i;
      end
      if (bus_rd_i) begin
        bus_rdata_o <= rd_mux;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // manual resync edge and sync pin input synchroniser
  logic manual_q;
  logic [2:0] pin_sync;
  logic pin_level;
  wire manual_rise = manual_bit && !manual_q;
  wire pin_input = sync_pin_direction && es_enable;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      manual_q <= 1'b0;
      pin_sync <= 3'h0;
      pin_level <= 1'b0;
    end else if (ce_i) begin
      manual_q <= manual_bit;
      pin_sync <= {pin_sync[1:0], rx_boundary_pin_i};
      pin_level <= pin_sync[1] == pin_sync[2] ? pin_sync[2] : pin_level;
    end
  end
  wire pin_rise = pin_sync[1] && pin_sync[2] && !pin_level;

  //////////////////////////////////////////////////////////////////////////
  // frame alignment
  e1rs_fstate_e fstate;
  e1rs_fstate_e next_fstate;
  logic [7:0] bitpos;
  e1rs_byte_t shreg;
  logic fas_frame;
  logic [1:0] fas_errs;
  logic [1:0] nfas_errs;
  wire e1rs_byte_t next_shreg = {shreg[6:0], rx_bit_i};
  wire step = ce_i && rx_bit_en_i;
  wire fas_hit = next_shreg[6:0] == `E1RS_FAS_WORD;
  wire ts0_end = bitpos == `E1RS_TS0_END;
  wire frame_end = bitpos == `E1RS_FRAME_END;
  wire in_fsync = fstate == E1RS_SYNC;
  wire fas_bad = ts0_end && fas_frame && !fas_hit;
  wire nfas_bad = ts0_end && !fas_frame && !next_shreg[6];
  wire [1:0] next_fas_errs = !(ts0_end && fas_frame) ? fas_errs :
    fas_bad ? fas_errs + {1'b0, fas_errs != `E1RS_FAS_ERR_LIMIT} : 2'h0;
  wire [1:0] next_nfas_errs = !(ts0_end && !fas_frame) ? nfas_errs :
    nfas_bad ? nfas_errs + {1'b0, nfas_errs != `E1RS_FAS_ERR_LIMIT} : 2'h0;
  wire f_crit = next_fas_errs == `E1RS_FAS_ERR_LIMIT ||
    (realign_criteria_select &&
     next_nfas_errs == `E1RS_FAS_ERR_LIMIT);
  wire f_lose = in_fsync && f_crit && !auto_realign_disable;

  always_comb begin
    next_fstate = fstate;
    case (fstate)
      E1RS_HUNT: begin
        if (fas_hit) begin
          next_fstate = E1RS_NFAS;
        end
      end
      E1RS_NFAS: begin
        if (ts0_end) begin
          next_fstate = next_shreg[6] ? E1RS_CONF : E1RS_HUNT;
        end
      end
      E1RS_CONF: begin
        if (ts0_end) begin
          next_fstate = fas_hit ? E1RS_SYNC : E1RS_HUNT;
        end
      end
      E1RS_SYNC: begin
        if (f_lose) begin
          next_fstate = E1RS_HUNT;
        end
      end
      default: next_fstate = E1RS_HUNT;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fstate <= E1RS_HUNT;
      bitpos <= 8'h00;
      shreg <= 8'h00;
      fas_frame <= 1'b0;
      fas_errs <= 2'h0;
      nfas_errs <= 2'h0;
    end else if (ce_i && manual_rise) begin
      fstate <= E1RS_HUNT;
    end else if (step) begin
      shreg <= next_shreg;
      fstate <= next_fstate;
      if (fstate == E1RS_HUNT && fas_hit) begin
        bitpos <= `E1RS_TS0_END + 8'h01;
        fas_frame <= 1'b1;
      end else begin
        bitpos <= bitpos + 8'h01;
        if (frame_end) begin
          fas_frame <= !fas_frame;
        end
      end
      fas_errs <= in_fsync ? next_fas_errs : 2'h0;
      nfas_errs <= in_fsync ? next_nfas_errs : 2'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // CRC4 multiframe alignment and code word checking
  logic crc_sync;
  logic [3:0] crc_fr;
  logic [5:0] mfa_bits;
  logic win_open;
  logic [6:0] win_cnt;
  logic [3:0] crc_acc;
  logic [3:0] crc_prev;
  logic [3:0] crc_rx;
  logic [9:0] crc_words;
  logic [9:0] crc_errs;
  wire c_bit_slot = bitpos == 8'h00 && fas_frame;
  wire crc_in = c_bit_slot ? 1'b0 : rx_bit_i;
  wire crc_fb = crc_in ^ crc_acc[3];
  wire [3:0] next_crc_acc = {crc_acc[2:0], crc_fb} ^ {2'h0, crc_fb, 1'b0};
  wire [5:0] next_mfa = {mfa_bits[4:0], next_shreg[7]};
  wire mfa_hit = ts0_end && !fas_frame && next_mfa == `E1RS_CRC_MFA_WORD;
  wire smf_end = frame_end && crc_fr[2:0] == 3'h7;
  wire word_bad = crc_rx != crc_prev;
  wire [9:0] next_crc_errs = crc_errs + {9'h000, word_bad};
  wire crc_lose = smf_end && crc_words == CRC_LAST &&
    next_crc_errs >= CRC_LIM && !auto_realign_disable;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      crc_sync <= 1'b0;
      crc_fr <= 4'h0;
      mfa_bits <= 6'h00;
      win_open <= 1'b0;
      win_cnt <= 7'h00;
      crc_acc <= 4'h0;
      crc_prev <= 4'h0;
      crc_rx <= 4'h0;
      crc_words <= 10'h000;
      crc_errs <= 10'h000;
    end else if (ce_i && (manual_rise || !in_fsync)) begin
      crc_sync <= 1'b0;
      win_open <= 1'b0;
      crc_words <= 10'h000;
      crc_errs <= 10'h000;
    end else if (step) begin
      if (ts0_end && !fas_frame) begin
        mfa_bits <= next_mfa;
      end
      if (!crc_sync) begin
        if (mfa_hit && win_open) begin
          crc_sync <= 1'b1;
          crc_fr <= 4'hB;
          crc_acc <= 4'h0;
        end else if (mfa_hit) begin
          win_open <= 1'b1;
          win_cnt <= 7'h00;
        end else if (frame_end && win_open) begin
          win_open <= win_cnt != WIN_LAST;
          win_cnt <= win_cnt + 7'h01;
        end
      end else begin
        if (c_bit_slot) begin
          crc_rx <= {crc_rx[2:0], rx_bit_i};
        end
        crc_acc <= smf_end ? 4'h0 : next_crc_acc;
        if (frame_end) begin
          crc_fr <= crc_fr + 4'h1;
        end
        if (smf_end) begin
          crc_prev <= next_crc_acc;
          crc_words <= crc_words == CRC_LAST ? 10'h000 :
            crc_words + 10'h001;
          crc_errs <= crc_words == CRC_LAST ? 10'h000 : next_crc_errs;
          if (crc_lose) begin
            crc_sync <= 1'b0;
            win_open <= 1'b0;
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // CAS multiframe alignment
  logic cas_sync;
  logic [3:0] cas_fr;
  e1rs_byte_t prev_ts16;
  logic [1:0] cas_errs;
  wire ts16_end = bitpos == `E1RS_TS16_END;
  wire cas_word = next_shreg[7:4] == 4'h0;
  wire cas_check = ts16_end && cas_fr == 4'h0;
  wire [1:0] next_cas_errs = cas_word ? 2'h0 : cas_errs + 2'h1;
  wire cas_lose = cas_check && next_cas_errs == `E1RS_CAS_ERR_LIMIT &&
    !auto_realign_disable;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cas_sync <= 1'b0;
      cas_fr <= 4'h0;
      prev_ts16 <= 8'h00;
      cas_errs <= 2'h0;
    end else if (ce_i && (manual_rise || !in_fsync)) begin
      cas_sync <= 1'b0;
      cas_errs <= 2'h0;
    end else if (step) begin
      if (ts16_end) begin
        prev_ts16 <= next_shreg;
      end
      if (!cas_sync) begin
        if (ts16_end && cas_word && prev_ts16 != 8'h00) begin
          cas_sync <= 1'b1;
          cas_fr <= 4'h0;
          cas_errs <= 2'h0;
        end
      end else begin
        if (frame_end) begin
          cas_fr <= cas_fr + 4'h1;
        end
        if (cas_check) begin
          cas_errs <= next_cas_errs;
          cas_sync <= !cas_lose;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // boundary pin and status outputs
  wire mf_mark = sync_pin_multiframe_function ?
    (crc_sync && crc_fr == 4'hF) :
    (cas_sync && cas_fr == 4'hF);
  wire mark = in_fsync && frame_end &&
    (sync_pin_mode ? mf_mark : fas_frame);

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_boundary_pin_o <= 1'b0;
      rx_boundary_pin_oe_o <= 1'b0;
      backplane_sync_o <= 1'b0;
      rx_elastic_store_enable_o <= 1'b0;
      backplane_clock_select_o <= 1'b0;
      frame_sync_o <= 1'b0;
      crc_mf_sync_o <= 1'b0;
      cas_mf_sync_o <= 1'b0;
    end else if (ce_i) begin
      rx_boundary_pin_o <= !pin_input && step && mark;
      rx_boundary_pin_oe_o <= !pin_input;
      backplane_sync_o <= pin_input && pin_rise;
      rx_elastic_store_enable_o <= es_enable;
      backplane_clock_select_o <= receive_control_two[`E1RS_RC2_BCS];
      frame_sync_o <= in_fsync;
      crc_mf_sync_o <= crc_sync;
      cas_mf_sync_o <= cas_sync;
    end
  end
endmodule

// file: e1rs_monitor.sv
`timescale 1ns/1ps
`include "e1rs_map.svh"
module e1rs_monitor #(
  parameter logic [3:0] REVISION = 4'h1,
  parameter logic LINE_TYPE = 1'b1
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [7:0] bus_rdata_o,
  input wire logic rx_bit_en_i,
  input wire logic rx_boundary_pin_o,
  input wire logic rx_boundary_pin_oe_o,
  input wire logic rx_elastic_store_enable_o,
  input wire logic frame_sync_o,
  input wire logic crc_mf_sync_o,
  input wire logic cas_mf_sync_o
);
  logic [7:0] sh1;
  logic [7:0] sh2;
  logic live;
  wire wr_hit = ce_i && bus_wr_i;
  wire rd_hit = ce_i && bus_rd_i;
  wire any_sync = frame_sync_o || crc_mf_sync_o || cas_mf_sync_o;
  // shadow copies of the control registers, updated like the host sees them
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sh1 <= 8'h00;
      sh2 <= 8'h00;
      live <= 1'b0;
    end else begin
      live <= 1'b1;
      if (wr_hit && bus_addr_i == `E1RS_ADDR_RC1)
        sh1 <= bus_wdata_i;
      if (wr_hit && bus_addr_i == `E1RS_ADDR_RC2)
        sh2 <= bus_wdata_i;
    end
  end
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  property p_id;
    rd_hit && bus_addr_i == `E1RS_ADDR_ID |=>
      bus_rdata_o == {LINE_TYPE, 3'b000, REVISION};
  endproperty
  a_id: assert property (p_id)
    else $error("identification read wrong");
  property p_rc2;
    rd_hit && bus_addr_i == `E1RS_ADDR_RC2 |=> bus_rdata_o == $past(sh2);
  endproperty
  a_rc2: assert property (p_rc2)
    else $error("control two read wrong");
  property p_oe;
    live && $past(ce_i) |->
      rx_boundary_pin_oe_o == !($past(sh1[5]) && $past(sh2[1]));
  endproperty
  a_oe: assert property (p_oe)
    else $error("pin direction wrong");
  property p_es;
    live && $past(ce_i) |-> rx_elastic_store_enable_o == $past(sh2[1]);
  endproperty
  a_es: assert property (p_es)
    else $error("store enable wrong");
  property p_pulse;
    rx_boundary_pin_o |=> !rx_boundary_pin_o;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("boundary pulse too long");
  property p_fsync;
    $rose(frame_sync_o) |-> $past(rx_bit_en_i && ce_i, 2);
  endproperty
  a_fsync: assert property (p_fsync)
    else $error("frame sync not after a bit");
  property p_manual;
    $rose(sh1[0]) |-> ##3 !any_sync;
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual resync ignored");
  property p_hold;
    live && sh1[1] && !sh1[0] && frame_sync_o |=> frame_sync_o;
  endproperty
  a_hold: assert property (p_hold)
    else $error("alignment lost with auto off");
endmodule
bind e1rs_receive_sync e1rs_monitor #(.REVISION(REVISION),
  .LINE_TYPE(LINE_TYPE)) u_mon (.sys_clk_i(sys_clk_i),
  .rst_b_i(rst_b_i), .ce_i(ce_i), .bus_addr_i(bus_addr_i),
  .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
  .bus_rdata_o(bus_rdata_o), .rx_bit_en_i(rx_bit_en_i),
  .rx_boundary_pin_o(rx_boundary_pin_o),
  .rx_boundary_pin_oe_o(rx_boundary_pin_oe_o),
  .rx_elastic_store_enable_o(rx_elastic_store_enable_o),
  .frame_sync_o(frame_sync_o), .crc_mf_sync_o(crc_mf_sync_o),
  .cas_mf_sync_o(cas_mf_sync_o));

// file: e1rs_line_model.sv
`timescale 1ns/1ps
`include "e1rs_map.svh"
module e1rs_line_model (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic slow_i,
  input wire logic bad_fas_i,
  input wire logic bad_nfas_i,
  input wire logic bad_cas_i,
  output logic rx_bit_o,
  output logic rx_bit_en_o,
  output logic [3:0] frame_o
);
  localparam logic [6:0] FAS = `E1RS_FAS_WORD;
  // crc4 alignment bits of the odd frames, then two spare ones
  localparam logic [7:0] MFA = {`E1RS_CRC_MFA_WORD, 2'b11};
  logic [7:0] pos;
  wire odd = frame_o[0];
  logic gap;
  logic val;
  // all other bits are ones so no false alignment word appears
  always_comb begin
    val = 1'b1;
    if (!odd && pos >= 8'd1 && pos <= 8'd7)
      val = FAS[3'(7 - pos)] ^ (bad_fas_i && pos == 8'd7);
    if (odd && pos == 8'd0)
      val = MFA[3'(7 - frame_o[3:1])];
    if (odd && pos == 8'd1)
      val = !bad_nfas_i;
    // cas word in timeslot 16 of frame 8, other timeslot 16 bytes nonzero
    if (frame_o == 4'd8 && pos >= 8'd128 && pos <= 8'd131)
      val = bad_cas_i;
  end
  always_ff @(negedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pos <= 8'h00;
      frame_o <= 4'h0;
      gap <= 1'b0;
      rx_bit_en_o <= 1'b0;
      rx_bit_o <= 1'b0;
    end else if (slow_i && !gap) begin
      gap <= 1'b1;
      rx_bit_en_o <= 1'b0;
      rx_bit_o <= !rx_bit_o;
    end else begin
      gap <= 1'b0;
      rx_bit_en_o <= 1'b1;
      rx_bit_o <= val;
      pos <= pos + 8'd1;
      if (pos == 8'hFF)
        frame_o <= frame_o + 4'd1;
    end
  end
endmodule

// file: e1_receive_sync_control_test.sv
`timescale 1ns/1ps
`include "e1rs_map.svh"
module e1_receive_sync_control_test;
  localparam logic [3:0] REV = 4'h1; // arbitrary value
  localparam logic LT = 1'b1;
  logic sys_clk_i = 1'b0, rst_b_i = 1'b0, bus_wr_i = 1'b0, bus_rd_i = 1'b0;
  logic slow = 1'b0, bad_fas = 1'b0, bad_nfas = 1'b0, bp_drv = 1'b0;
  logic [7:0] bus_addr_i = 8'h00, bus_wdata_i = 8'h00;
  logic [7:0] bus_rdata_o;
  logic rx_bit, rx_en, pin_o, oe_o, bp_sync, es_o, bcs_o, fs;
  logic bad_cas = 1'b0, crc_s, cas_s;
  logic [3:0] mf_fr;
  logic [31:0] seed = 32'd93;
  int mismatches = 0, total_checks = 0, cycles = 0, n;
  wire pin = oe_o ? pin_o : bp_drv;
  initial forever #20 sys_clk_i = ~sys_clk_i;
  e1rs_receive_sync #(.REVISION(REV), .LINE_TYPE(LT)) dut (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
    .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
    .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o),
    .rx_bit_i(rx_bit), .rx_bit_en_i(rx_en), .rx_boundary_pin_i(pin),
    .rx_boundary_pin_o(pin_o), .rx_boundary_pin_oe_o(oe_o),
    .backplane_sync_o(bp_sync), .rx_elastic_store_enable_o(es_o),
    .backplane_clock_select_o(bcs_o), .frame_sync_o(fs),
    .crc_mf_sync_o(crc_s), .cas_mf_sync_o(cas_s));
  e1rs_line_model u_line (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .slow_i(slow), .bad_fas_i(bad_fas), .bad_nfas_i(bad_nfas),
    .bad_cas_i(bad_cas), .rx_bit_o(rx_bit), .rx_bit_en_o(rx_en),
    .frame_o(mf_fr));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [7:0] idv();
    return {LT, 3'b000, REV};
  endfunction
  function automatic logic oe_exp(input logic [7:0] c1, input logic [7:0] c2);
    return !(c1[5] && c2[1]);
  endfunction
  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task chkf(input logic got, input logic exp, input string m);
    chk({7'h00, got}, {7'h00, exp}, m);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    bus_addr_i = a;
    bus_wdata_i = d;
    bus_wr_i = 1'b1;
    @(negedge sys_clk_i);
    bus_wr_i = 1'b0;
  endtask
  task rc(input logic [7:0] a, input logic [7:0] exp, input string m);
    @(negedge sys_clk_i);
    bus_addr_i = a;
    bus_rd_i = 1'b1;
    @(negedge sys_clk_i);
    bus_rd_i = 1'b0;
    @(negedge sys_clk_i);
    chk(bus_rdata_o, exp, m);
  endtask
  task wait_fs(input logic v, input int lim);
    for (int i = 0; i < lim && fs !== v; i++) @(negedge sys_clk_i);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      tally_and_finish;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d1, d2;
    repeat (8) @(negedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(negedge sys_clk_i);
    chkf(oe_o, 1'b1, "oe after reset");
    for (int a = 0; a <= 8'hBF; a++) wr(8'(a), 8'h00);
    rc(`E1RS_ADDR_ID, idv(), "id");
    wr(`E1RS_ADDR_ID, 8'h55);
    rc(`E1RS_ADDR_ID, idv(), "id after write");
    rc(8'hC3, 8'h00, "unmapped");
    for (int i = 0; i < 8; i++) begin
      d1 = (i > 0) ? (rnd() & 8'hE6) : 8'hC4;
      d2 = (i > 0) ? (rnd() & 8'hFE) : 8'hFC;
      if (!d2[1]) d1[5] = 1'b0;
      wr(`E1RS_ADDR_RC1, d1);
      wr(`E1RS_ADDR_RC2, d2);
      rc(`E1RS_ADDR_RC1, d1, "ctl one");
      rc(`E1RS_ADDR_RC2, d2, "ctl two");
      chkf(es_o, d2[1], "store enable");
      chkf(bcs_o, d2[2], "clock select");
      chkf(oe_o, oe_exp(d1, d2), "pin enable");
    end
    wr(`E1RS_ADDR_RC2, 8'h02);
    wr(`E1RS_ADDR_RC1, 8'h20);
    @(negedge sys_clk_i);
    chkf(oe_o, 1'b0, "input mode");
    bp_drv = 1'b1;
    for (int i = 0; i < 8 && bp_sync !== 1'b1; i++) @(negedge sys_clk_i);
    chkf(bp_sync, 1'b1, "backplane sync");
    bp_drv = 1'b0;
    wait_fs(1'b1, 3000);
    chkf(fs, 1'b1, "synced before resync");
    wr(`E1RS_ADDR_RC1, 8'h01);
    wr(`E1RS_ADDR_RC2, 8'h00); // store off, its reset step skipped
    repeat (4) @(negedge sys_clk_i);
    chkf(fs, 1'b0, "manual resync");
    slow <= 1'b1;
    wait_fs(1'b1, 3000);
    chkf(fs, 1'b1, "frame sync");
    wr(`E1RS_ADDR_RC1, 8'h01);
    repeat (4) @(negedge sys_clk_i);
    chkf(fs, 1'b1, "no second resync");
    wr(`E1RS_ADDR_RC1, 8'h00);
    slow <= 1'b0;
    for (n = 0; n < 600 && pin_o !== 1'b1; n++) @(negedge sys_clk_i);
    @(negedge sys_clk_i);
    for (n = 1; n < 600 && pin_o !== 1'b1; n++) @(negedge sys_clk_i);
    chkf(n == 512, 1'b1, "boundary spacing");
    bad_nfas <= 1'b1;
    repeat (1600) @(negedge sys_clk_i);
    chkf(fs, 1'b1, "nfas ignored");
    wr(`E1RS_ADDR_RC1, 8'h04);
    repeat (1600) @(negedge sys_clk_i);
    chkf(fs, 1'b0, "nfas loss");
    bad_nfas <= 1'b0;
    wait_fs(1'b1, 2500);
    chkf(fs, 1'b1, "realigned");
    wr(`E1RS_ADDR_RC1, 8'h02);
    bad_fas <= 1'b1;
    repeat (1600) @(negedge sys_clk_i);
    chkf(fs, 1'b1, "auto off kept");
    wr(`E1RS_ADDR_RC1, 8'h00);
    repeat (1600) @(negedge sys_clk_i);
    chkf(fs, 1'b0, "fas loss");
    bad_fas <= 1'b0;
    wait_fs(1'b1, 2500);
    chkf(fs, 1'b1, "realigned");
    for (n = 0; n < 12000 && crc_s !== 1'b1; n++) @(negedge sys_clk_i);
    chkf(crc_s, 1'b1, "crc4 sync");
    chkf(cas_s, 1'b1, "cas sync");
    wr(`E1RS_ADDR_RC1, 8'hC0);
    @(negedge sys_clk_i);
    for (n = 0; n < 4200 && pin_o !== 1'b1; n++) @(negedge sys_clk_i);
    chk({pin_o, 3'h0, mf_fr}, 8'h80, "crc4 boundary");
    @(negedge sys_clk_i);
    for (n = 1; n < 4200 && pin_o !== 1'b1; n++) @(negedge sys_clk_i);
    chkf(n == 4096, 1'b1, "multiframe spacing");
    wr(`E1RS_ADDR_RC1, 8'h40);
    @(negedge sys_clk_i);
    for (n = 0; n < 4200 && pin_o !== 1'b1; n++) @(negedge sys_clk_i);
    chk({pin_o, 3'h0, mf_fr}, 8'h88, "cas boundary");
    bad_cas <= 1'b1;
    for (n = 0; n < 9000 && cas_s !== 1'b0; n++) @(negedge sys_clk_i);
    chkf(cas_s, 1'b0, "cas loss");
    chkf(crc_s, 1'b1, "crc4 kept");
    bad_cas <= 1'b0;
    tally_and_finish;
  end
endmodule
